// *** rtl/flash_sequencer.sv ***
// Purpose: Program-store write, pair write, key and page-lock control
// Assumes: Array takes one-cycle commands, raises busy the next cycle
// Notes:   Fault flag survives srst and clears only on power-on reset
`timescale 1ns/100ps
module flash_sequencer import flash_seq_pkg::*; #(
  parameter int              ADDR_W    = 14,
  parameter logic [13:0]     LOCK_ADDR = 14'h3bff,
  parameter logic [13:0]     RESV_BASE = 14'h3c00
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              srst,
  input  wire logic              por_rst,
  // Control register writes
  input  wire logic              ctl_wr,
  input  wire logic [1:0]        ctl_wdata,
  input  wire logic              key_wr,
  input  wire logic [7:0]        key_wdata,
  input  wire logic              pair_write_enable,
  // Core requests
  input  wire core_kind_t        core_kind,
  input  wire logic [ADDR_W-1:0] core_addr,
  input  wire logic [7:0]        core_wdata,
  input  wire logic [ADDR_W-1:0] exec_addr,
  // Core answers
  output logic                   core_stall,
  output logic                   core_rvalid,
  output logic [7:0]             core_rdata,
  output logic                   ext_ram_rd,
  output logic                   ext_ram_wr,
  output logic                   irq_hold,
  // Debug port requests
  input  wire logic              dbg_valid,
  input  wire flash_op_t         dbg_op,
  input  wire logic [ADDR_W-1:0] dbg_addr,
  input  wire logic [7:0]        dbg_wdata,
  // Debug port answers
  output logic                   dbg_done,
  output logic                   dbg_denied,
  output logic [7:0]             dbg_rdata,
  // Flash array
  output arr_cmd_t               arr_cmd,
  output logic [ADDR_W-1:0]      arr_addr,
  output logic [15:0]            arr_wdata,
  output logic                   arr_pair,
  input  wire logic              arr_busy,
  input  wire logic [7:0]        arr_rdata,
  // Status
  output logic                   store_write_enable,
  output logic                   store_erase_enable,
  output key_t                   key_state,
  output logic [7:0]             lock_setting,
  output logic                   flash_fault_flag,
  output logic                   sys_reset_req
);

  typedef enum logic [2:0] {
    st_load,
    st_load_wait,
    st_idle,
    st_kick,
    st_wait,
    st_read,
    st_halt
  } state_t;

  typedef struct packed {
    state_t            st;
    key_t              key;
    logic              swe;
    logic              see;
    logic              cache_v;
    logic [ADDR_W-1:0] cache_addr;
    logic [7:0]        cache_data;
    logic [7:0]        lock;
    logic              lock_written;
    logic              fault;
    logic              for_dbg;
    logic              is_mass;
    arr_cmd_t          cmd;
    logic [ADDR_W-1:0] a_addr;
    logic [15:0]       a_wdata;
    logic              a_pair;
    logic              stall;
    logic              rvalid;
    logic [7:0]        rdata;
    logic              xrd;
    logic              xwr;
    logic              d_done;
    logic              d_denied;
    logic [7:0]        d_rdata;
    logic              rst_req;
    logic              irq_hold;
  } seq_t;

  seq_t s_q;
  seq_t s_d;

  // Access policy inputs
  logic              use_dbg;
  logic [ADDR_W-1:0] pol_addr;
  flash_op_t         pol_op;
  verdict_t          verdict;
  logic              is_lock_byte;

  always_comb begin
    use_dbg  = (core_kind == kind_none) && dbg_valid;
    pol_addr = use_dbg ? dbg_addr : core_addr;
    if (use_dbg) begin
      pol_op = dbg_op;
    end else if (core_kind == kind_code_read) begin
      pol_op = op_read;
    end else begin
      pol_op = s_q.see ? op_erase : op_write;
    end
  end

  lock_policy #(
    .ADDR_W    (ADDR_W),
    .LOCK_ADDR (LOCK_ADDR),
    .RESV_BASE (RESV_BASE)
  ) u_policy (
    .addr         (pol_addr),
    .op           (pol_op),
    .from_dbg     (use_dbg),
    .exec_addr    (exec_addr),
    .lock_byte    (s_q.lock),
    .lock_written (s_q.lock_written),
    .verdict      (verdict),
    .is_lock_byte (is_lock_byte)
  );

  always_comb begin
    s_d          = s_q;
    s_d.cmd      = cmd_none;
    s_d.rvalid   = 1'b0;
    s_d.xrd      = 1'b0;
    s_d.xwr      = 1'b0;
    s_d.d_done   = 1'b0;
    s_d.d_denied = 1'b0;
    s_d.rst_req  = 1'b0;
    // Enable bits from the store control register
    if (ctl_wr) begin
      s_d.swe = ctl_wdata[0];
      s_d.see = ctl_wdata[1];
    end
    // Lone cached byte is dropped once the pair sequence is left
    if (!pair_write_enable || !s_d.swe || s_d.see) begin
      s_d.cache_v = 1'b0;
    end
    case (s_q.st)
      st_load: begin
        // Lock setting is read from the array only here, after every reset; a mass erase sets it to erased
        s_d.cmd    = cmd_read;
        s_d.a_addr = LOCK_ADDR;
        s_d.st     = st_load_wait;
      end
      st_load_wait: begin
        s_d.lock  = arr_rdata;
        s_d.lock_written = (arr_rdata != LOCK_ERASED);
        s_d.stall = 1'b0;
        s_d.st    = st_idle;
      end
      st_idle: begin
        if (core_kind == kind_xmove_read) begin
          s_d.xrd = 1'b1;
        end else if (core_kind == kind_code_read) begin
          if (verdict == vd_allow) begin
            s_d.cmd     = cmd_read;
            s_d.a_addr  = core_addr;
            s_d.for_dbg = 1'b0;
            s_d.stall   = 1'b1;
            s_d.st      = st_read;
          end else if (verdict == vd_ignore) begin
            s_d.rvalid = 1'b1;
            s_d.rdata  = RESV_RDATA;
          end else begin
            s_d.fault   = 1'b1;
            s_d.rst_req = 1'b1;
            s_d.stall   = 1'b1;
            s_d.st      = st_halt;
          end
        end else if (core_kind == kind_xmove_write) begin
          if (!s_q.swe) begin
            s_d.xwr = 1'b1;
          end else if (s_q.key != key_armed) begin
            s_d.key = key_dead;
          end else if (verdict == vd_fault) begin
            s_d.fault   = 1'b1;
            s_d.rst_req = 1'b1;
            s_d.stall   = 1'b1;
            s_d.st      = st_halt;
          end else begin
            s_d.key = key_idle;
            if (verdict == vd_allow) begin
              s_d.for_dbg = 1'b0;
              s_d.is_mass = 1'b0;
              s_d.a_pair  = 1'b0;
              if (s_q.see) begin
                s_d.cmd    = cmd_erase;
                s_d.a_addr = core_addr;
                s_d.stall  = 1'b1;
                s_d.st     = st_kick;
              end else if (pair_write_enable && !s_q.cache_v) begin
                s_d.cache_v    = 1'b1;
                s_d.cache_addr = core_addr;
                s_d.cache_data = core_wdata;
              end else if (pair_write_enable &&
                           (core_addr != s_q.cache_addr + ADDR_W'(1))) begin
                s_d.cache_addr = core_addr;
                s_d.cache_data = core_wdata;
              end else begin
                s_d.cmd     = cmd_prog;
                s_d.a_pair  = pair_write_enable;
                s_d.a_addr  = pair_write_enable ? s_q.cache_addr : core_addr;
                s_d.a_wdata = pair_write_enable ? {core_wdata, s_q.cache_data}
                                                : {DATA_RST, core_wdata};
                s_d.cache_v = 1'b0;
                s_d.stall   = 1'b1;
                s_d.st      = st_kick;
                if (is_lock_byte || (pair_write_enable &&
                    (s_q.cache_addr == LOCK_ADDR))) begin
                  s_d.lock_written = 1'b1;
                end
              end
            end
          end
        end else if (dbg_valid) begin
          s_d.for_dbg = 1'b1;
          s_d.is_mass = (dbg_op == op_mass);
          s_d.a_pair  = 1'b0;
          s_d.a_addr  = dbg_addr;
          s_d.a_wdata = {DATA_RST, dbg_wdata};
          if (verdict != vd_allow) begin
            s_d.d_denied = 1'b1;
          end else begin
            s_d.stall = 1'b1;
            case (dbg_op)
              op_read: begin
                s_d.cmd = cmd_read;
                s_d.st  = st_read;
              end
              op_write: begin
                s_d.cmd = cmd_prog;
                s_d.st  = st_kick;
                if (is_lock_byte) begin
                  s_d.lock_written = 1'b1;
                end
              end
              op_erase: begin
                s_d.cmd = cmd_erase;
                s_d.st  = st_kick;
              end
              default: begin
                s_d.cmd = cmd_mass;
                s_d.st  = st_kick;
              end
            endcase
          end
        end
        // Interrupts held from the cycle a program or erase command is issued, one cycle before busy
        s_d.irq_hold = (s_d.st == st_kick);
      end
      st_kick: begin
        s_d.st = st_wait;
      end
      st_wait: begin
        if (!arr_busy) begin
          if (s_q.is_mass) begin
            s_d.lock         = LOCK_ERASED;
            s_d.lock_written = 1'b0;
            s_d.is_mass      = 1'b0;
          end
          s_d.d_done   = s_q.for_dbg;
          s_d.stall    = 1'b0;
          s_d.irq_hold = 1'b0;
          s_d.st       = st_idle;
        end
      end
      st_read: begin
        if (s_q.for_dbg) begin
          s_d.d_done  = 1'b1;
          s_d.d_rdata = arr_rdata;
        end else begin
          s_d.rvalid = 1'b1;
          s_d.rdata  = arr_rdata;
        end
        s_d.stall = 1'b0;
        s_d.st    = st_idle;
      end
      st_halt: begin
        s_d.stall = 1'b1;
      end
      default: begin
        s_d.st = st_load;
      end
    endcase
    // Key register writes
    if (key_wr) begin
      case (s_d.key)
        key_idle:  s_d.key = (key_wdata == KEY_FIRST)  ? key_half  : key_dead;
        key_half:  s_d.key = (key_wdata == KEY_SECOND) ? key_armed : key_dead;
        key_armed: s_d.key = key_dead;
        default:   s_d.key = key_dead;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      s_q              <= '0;
      s_q.st           <= st_load;
      s_q.key          <= key_idle;
      s_q.cmd          <= cmd_none;
      s_q.lock         <= LOCK_ERASED;
      s_q.lock_written <= 1'b0;
      s_q.stall        <= 1'b1;
      s_q.fault        <= s_q.fault & ~por_rst;
    end else begin
      s_q <= s_d;
    end
  end

  assign core_stall         = s_q.stall;
  assign core_rvalid        = s_q.rvalid;
  assign core_rdata         = s_q.rdata;
  assign ext_ram_rd         = s_q.xrd;
  assign ext_ram_wr         = s_q.xwr;
  assign irq_hold           = s_q.irq_hold;
  assign dbg_done           = s_q.d_done;
  assign dbg_denied         = s_q.d_denied;
  assign dbg_rdata          = s_q.d_rdata;
  assign arr_cmd            = s_q.cmd;
  assign arr_addr           = s_q.a_addr;
  assign arr_wdata          = s_q.a_wdata;
  assign arr_pair           = s_q.a_pair;
  assign store_write_enable = s_q.swe;
  assign store_erase_enable = s_q.see;
  assign key_state          = s_q.key;
  assign lock_setting       = s_q.lock;
  assign flash_fault_flag   = s_q.fault;
  assign sys_reset_req      = s_q.rst_req;

endmodule // flash_sequencer

// *** rtl/flash_seq_pkg.sv ***
// Purpose: Shared constants and types for the program-store sequencer
// Assumes: Byte-wide flash array organised in 512-byte pages
// Notes:   Operation and verdict enumerations are shared by the sequencer and its access policy
package flash_seq_pkg;

  // Unlock key sequence
  localparam logic [7:0] KEY_FIRST    = 8'ha5;
  localparam logic [7:0] KEY_SECOND   = 8'hf1;

  // Page geometry: 512-byte pages, page 0 spans 0x0000 to 0x01ff
  localparam int         PAGE_BITS    = 9;
  localparam logic [7:0] LOCK_ERASED  = 8'hff;

  // Reset values
  localparam logic [7:0] DATA_RST     = 8'h00;
  localparam logic [7:0] RESV_RDATA   = 8'h00;

  // Flash operations seen by the access policy
  typedef enum logic [1:0] {
    op_read,
    op_write,
    op_erase,
    op_mass
  } flash_op_t;

  // Verdict of the access policy
  typedef enum logic [1:0] {
    vd_allow,
    vd_deny,
    vd_fault,
    vd_ignore
  } verdict_t;

  // Core request kinds
  typedef enum logic [1:0] {
    kind_none,
    kind_code_read,
    kind_xmove_read,
    kind_xmove_write
  } core_kind_t;

  // Commands to the flash array
  typedef enum logic [2:0] {
    cmd_none,
    cmd_read,
    cmd_prog,
    cmd_erase,
    cmd_mass
  } arr_cmd_t;

  // Unlock key state
  typedef enum logic [1:0] {
    key_idle,
    key_half,
    key_armed,
    key_dead
  } key_t;

endpackage

// *** rtl/lock_policy.sv ***
// Purpose: Page-lock permission check for one flash access
// Assumes: Lock byte value latched at reset and set to erased by a mass erase, executing address from the core
// Notes:   Purely combinational; the sequencer registers every consequence
`timescale 1ns/100ps
module lock_policy import flash_seq_pkg::*; #(
  parameter int              ADDR_W    = 14,
  parameter logic [13:0]     LOCK_ADDR = 14'h3bff,
  parameter logic [13:0]     RESV_BASE = 14'h3c00
) (
  // Access under test
  input  wire logic [ADDR_W-1:0] addr,
  input  wire flash_op_t         op,
  input  wire logic              from_dbg,
  input  wire logic [ADDR_W-1:0] exec_addr,
  // Lock state
  input  wire logic [7:0]        lock_byte,
  input  wire logic              lock_written,
  // Result
  output verdict_t               verdict,
  output logic                   is_lock_byte
);

  logic [7:0]              npages;
  logic                    any_locked;
  logic [7:0]              page_a;
  logic [7:0]              page_x;
  logic [7:0]              page_l;
  logic                    addr_locked;
  logic                    exec_locked;
  logic                    resv;

  always_comb begin
    npages       = ~lock_byte;
    any_locked   = (npages != 8'h00);
    page_a       = 8'(addr >> PAGE_BITS);
    page_x       = 8'(exec_addr >> PAGE_BITS);
    page_l       = 8'(LOCK_ADDR >> PAGE_BITS);
    addr_locked  = (page_a < npages) || ((page_a == page_l) && any_locked);
    exec_locked  = (page_x < npages) || ((page_x == page_l) && any_locked);
    resv         = (addr >= RESV_BASE);
    is_lock_byte = (addr == LOCK_ADDR);
    if (op == op_mass) begin
      verdict = from_dbg ? vd_allow : vd_fault;
    end else if (resv) begin
      verdict = from_dbg ? vd_deny : vd_ignore;
    end else if ((op == op_erase) && (page_a == page_l)) begin
      if (from_dbg) begin
        verdict = any_locked ? vd_deny : vd_allow;
      end else begin
        verdict = vd_fault;
      end
    end else if ((op == op_write) && is_lock_byte && lock_written) begin
      verdict = from_dbg ? vd_deny : vd_fault;
    end else if (addr_locked) begin
      if (from_dbg) begin
        verdict = vd_deny;
      end else begin
        verdict = exec_locked ? vd_allow : vd_fault;
      end
    end else begin
      verdict = vd_allow;
    end
  end

endmodule // lock_policy

// *** test/flash_seq_assertions.sv ***
// Purpose: Port properties of the program-store sequencer
// Assumes: One clock, srst disables every property
// Notes:   Bound from the bench top file
`timescale 1ns/100ps
module flash_seq_assertions import flash_seq_pkg::*; #(
  parameter logic [13:0] LOCK_ADDR = 14'h3bff,
  parameter logic [13:0] RESV_BASE = 14'h3c00
) (
  // Clock and reset
  input wire logic        clock,
  input wire logic        srst,
  // Requests
  input wire logic        pair_write_enable,
  input wire core_kind_t  core_kind,
  input wire logic [13:0] core_addr,
  input wire logic        dbg_valid,
  input wire logic [13:0] dbg_addr,
  // Answers
  input wire logic        core_stall,
  input wire logic        core_rvalid,
  input wire logic        ext_ram_rd,
  input wire logic        ext_ram_wr,
  input wire logic        irq_hold,
  input wire logic        dbg_denied,
  input wire arr_cmd_t    arr_cmd,
  input wire logic        arr_pair,
  input wire logic        arr_busy,
  // Status
  input wire logic        store_write_enable,
  input wire logic        store_erase_enable,
  input wire key_t        key_state,
  input wire logic [7:0]  lock_setting,
  input wire logic        flash_fault_flag,
  input wire logic        sys_reset_req
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  sequence s_take(core_kind_t k);
    !core_stall && core_kind == k;
  endsequence
  sequence s_keyed;
    s_take(kind_xmove_write) ##0 store_write_enable && key_state == key_armed
      && lock_setting == 8'hff && core_addr[13:9] != LOCK_ADDR[13:9] && core_addr < RESV_BASE;
  endsequence
  sequence s_read_answer;
    arr_cmd == cmd_read ##1 core_rvalid;
  endsequence

  a_code_read: assert property (s_take(kind_code_read) ##0 lock_setting == 8'hff
    && core_addr < RESV_BASE |=> s_read_answer) else $error("code read not answered");
  a_xread_ram: assert property (s_take(kind_xmove_read) |=> ext_ram_rd && arr_cmd == cmd_none)
    else $error("external read reached flash");
  a_write_gate: assert property (s_take(kind_xmove_write) ##0 !store_write_enable
    |=> ext_ram_wr && arr_cmd == cmd_none) else $error("disabled write reached flash");
  a_key_gate: assert property (s_take(kind_xmove_write) ##0 store_write_enable
    && key_state != key_armed |=> arr_cmd == cmd_none) else $error("unkeyed flash op");
  a_keyed_prog: assert property (s_keyed ##0 !store_erase_enable && !pair_write_enable
    |=> arr_cmd == cmd_prog && !arr_pair ##1 core_stall) else $error("keyed write lost");
  a_keyed_erase: assert property (s_keyed ##0 store_erase_enable
    |=> arr_cmd == cmd_erase) else $error("keyed erase lost");
  a_op_holds: assert property ((arr_cmd == cmd_prog || arr_cmd == cmd_erase)
    |-> core_stall && irq_hold) else $error("operation without hold");
  a_irq_release: assert property (irq_hold && !arr_busy ##1 !arr_busy |-> ##[0:2] !irq_hold)
    else $error("hold not released");
  a_fault_pulse: assert property (sys_reset_req |-> flash_fault_flag && core_stall
    ##1 !sys_reset_req) else $error("fault reset malformed");
  a_flag_kept: assert property (flash_fault_flag |=> flash_fault_flag)
    else $error("fault flag lost");
  a_dbg_no_reset: assert property (s_take(kind_none) ##0 dbg_valid |=> !sys_reset_req)
    else $error("debug caused reset");
  a_dbg_reserved: assert property (s_take(kind_none) ##0 dbg_valid && dbg_addr >= RESV_BASE
    |=> dbg_denied) else $error("reserved debug access");
endmodule // flash_seq_assertions

// *** test/flash_array_model.sv ***
// Purpose: Behavioural flash array facing the sequencer
// Assumes: Erased bytes read ff, busy starts the cycle after a command
// Notes:   Read data is scrambled unless a read command stands
`timescale 1ns/100ps
module flash_array_model import flash_seq_pkg::*; #(
  parameter int BUSY_CYC = 3
) (
  input  wire logic        clock,
  input  wire arr_cmd_t    arr_cmd,
  input  wire logic [13:0] arr_addr,
  input  wire logic [15:0] arr_wdata,
  input  wire logic        arr_pair,
  output logic             arr_busy,
  output logic [7:0]       arr_rdata
);
  logic [7:0] mem [0:16383];
  int         left = 0;
  initial begin
    foreach (mem[i])
      mem[i] = 8'hff;
  end
  assign arr_rdata = (arr_cmd == cmd_read) ? mem[arr_addr] : ~mem[arr_addr];
  assign arr_busy  = (left != 0);
  always @(posedge clock) begin
    if (left != 0)
      left <= left - 1;
    if (arr_cmd == cmd_prog) begin
      mem[arr_addr] <= mem[arr_addr] & arr_wdata[7:0];
      if (arr_pair)
        mem[arr_addr + 14'h1] <= mem[arr_addr + 14'h1] & arr_wdata[15:8];
      left <= BUSY_CYC;
    end
    if (arr_cmd == cmd_erase) begin
      for (int i = 0; i < 512; i++)
        mem[{arr_addr[13:9], 9'(i)}] <= 8'hff;
      left <= BUSY_CYC;
    end
    if (arr_cmd == cmd_mass) begin
      foreach (mem[i])
        mem[i] <= 8'hff;
      left <= BUSY_CYC;
    end
  end
endmodule // flash_array_model

// *** test/flash_sequencer_bench.sv ***
// Purpose: Self-checking bench for the program-store sequencer
// Assumes: Inputs change at the falling clock edge
// Notes:   Lock byte is preloaded in the array model
`timescale 1ns/100ps
module flash_sequencer_bench;
  import flash_seq_pkg::*;
  localparam logic [13:0] LOCK_ADDR = 14'h3bff;
  localparam logic [13:0] RESV_BASE = 14'h3c00;
  logic clock = 0, srst = 1, por_rst = 1, ctl_wr = 0, key_wr = 0, pair_write_enable = 0;
  logic dbg_valid = 0;
  logic [1:0] ctl_wdata = 0;
  logic [7:0] key_wdata = 0, core_wdata = 0, dbg_wdata = 0;
  logic [13:0] core_addr = 0, exec_addr = 14'h1000, dbg_addr = 0;
  core_kind_t core_kind = kind_none;
  flash_op_t dbg_op = op_read;
  logic core_stall, core_rvalid, ext_ram_rd, ext_ram_wr, irq_hold, dbg_done, dbg_denied;
  logic arr_pair, arr_busy, store_write_enable, store_erase_enable, flash_fault_flag;
  logic sys_reset_req;
  logic [7:0] core_rdata, dbg_rdata, lock_setting, arr_rdata;
  logic [13:0] arr_addr;
  logic [15:0] arr_wdata;
  arr_cmd_t arr_cmd;
  key_t key_state;
  int failures = 0, total_checks = 0, cycles = 0, n_prog = 0;

  flash_sequencer #(.LOCK_ADDR(LOCK_ADDR), .RESV_BASE(RESV_BASE)) dut (
    .clock, .srst, .por_rst, .ctl_wr, .ctl_wdata, .key_wr, .key_wdata, .pair_write_enable,
    .core_kind, .core_addr, .core_wdata, .exec_addr, .core_stall, .core_rvalid, .core_rdata,
    .ext_ram_rd, .ext_ram_wr, .irq_hold, .dbg_valid, .dbg_op, .dbg_addr, .dbg_wdata, .dbg_done,
    .dbg_denied, .dbg_rdata, .arr_cmd, .arr_addr, .arr_wdata, .arr_pair, .arr_busy, .arr_rdata,
    .store_write_enable, .store_erase_enable, .key_state, .lock_setting, .flash_fault_flag,
    .sys_reset_req);
  flash_array_model arr (.clock, .arr_cmd, .arr_addr, .arr_wdata, .arr_pair, .arr_busy,
    .arr_rdata);

  always #12.5 clock = ~clock;
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (arr_cmd == cmd_prog)
      n_prog <= n_prog + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic wait_idle();
    int n = 0;
    @(negedge clock);
    while (core_stall !== 1'b0 && n < 60) begin
      @(negedge clock);
      n++;
    end
    chk(core_stall, 0);
  endtask
  task automatic do_reset(input logic por);
    srst = 1;
    por_rst = por;
    repeat (6) @(negedge clock);
    srst = 0;
    por_rst = 0;
    wait_idle();
  endtask
  task automatic pulse_ctl(input logic [1:0] d);
    ctl_wr = 1;
    ctl_wdata = d;
    @(negedge clock);
    ctl_wr = 0;
  endtask
  task automatic keys();
    key_wr = 1;
    key_wdata = KEY_FIRST;
    @(negedge clock);
    key_wdata = KEY_SECOND;
    @(negedge clock);
    key_wr = 0;
  endtask
  task automatic core_req(input core_kind_t k, input logic [13:0] a, input logic [7:0] d);
    core_kind = k;
    core_addr = a;
    core_wdata = d;
    @(negedge clock);
    core_kind = kind_none;
  endtask
  task automatic dbg_req(input flash_op_t op, input logic [13:0] a, input logic den);
    int n = 0;
    dbg_valid = 1;
    dbg_op = op;
    dbg_addr = a;
    @(negedge clock);
    dbg_valid = 0;
    while (dbg_done !== 1'b1 && dbg_denied !== 1'b1 && n < 60) begin
      @(negedge clock);
      n++;
    end
    chk({dbg_denied, dbg_done, sys_reset_req}, {den, !den, 1'b0});
    wait_idle();
  endtask

  task automatic t_write();
    pulse_ctl(2'b01);
    chk({store_erase_enable, store_write_enable}, 2'b01);
    keys();
    core_req(kind_xmove_write, 14'h0810, 8'h5a);
    chk({arr_cmd, arr_pair, arr_addr}, {cmd_prog, 1'b0, 14'h0810});
    chk({arr_wdata[7:0], core_stall, irq_hold}, {8'h5a, 2'b11});
    wait_idle();
    chk({key_state, arr.mem[14'h0810]}, {key_idle, 8'h5a});
    core_req(kind_xmove_write, 14'h0811, 8'h00);
    @(negedge clock);
    chk(key_state, key_dead);
    keys();
    core_req(kind_xmove_write, 14'h0811, 8'h00);
    chk(arr_cmd, cmd_none);
    pulse_ctl(2'b00);
    chk({store_erase_enable, store_write_enable}, 2'b00);
  endtask
  task automatic t_pair();
    int s;
    pulse_ctl(2'b11);
    keys();
    core_req(kind_xmove_write, 14'h0a00, 8'h00);
    wait_idle();
    pair_write_enable = 1;
    pulse_ctl(2'b01);
    keys();
    core_req(kind_xmove_write, 14'h0a05, 8'hee);
    keys();
    core_req(kind_xmove_write, 14'h0a00, 8'h12);
    chk({arr_cmd, core_stall}, {cmd_none, 1'b0});
    keys();
    core_req(kind_xmove_write, 14'h0a01, 8'h34);
    chk({arr_cmd, arr_pair, arr_addr}, {cmd_prog, 1'b1, 14'h0a00});
    chk(arr_wdata, 16'h3412);
    wait_idle();
    chk({arr.mem[14'h0a00], arr.mem[14'h0a01]}, 16'h1234);
    s = n_prog;
    keys();
    core_req(kind_xmove_write, 14'h0a02, 8'h00);
    pair_write_enable = 0;
    repeat (4) @(negedge clock);
    chk({16'(n_prog - s), arr.mem[14'h0a02], arr.mem[14'h0a05]}, {16'h0, 16'hffff});
  endtask
  task automatic t_erase();
    arr.mem[14'h0c40] = 8'h00;
    pulse_ctl(2'b11);
    keys();
    core_req(kind_xmove_write, 14'h0c05, 8'h77);
    chk(arr_cmd, cmd_erase);
    wait_idle();
    core_req(kind_code_read, 14'h0c40, 8'h00);
    @(negedge clock);
    chk({core_rvalid, core_rdata}, 9'h1ff);
    pulse_ctl(2'b10);
    core_req(kind_xmove_write, 14'h0c40, 8'h00);
    chk({ext_ram_wr, arr_cmd}, {1'b1, cmd_none});
    core_req(kind_xmove_read, 14'h0c40, 8'h00);
    chk({ext_ram_rd, arr_cmd}, {1'b1, cmd_none});
  endtask
  task automatic t_lock();
    arr.mem[LOCK_ADDR] = 8'hfd;
    do_reset(0);
    chk(lock_setting, 8'hfd);
    dbg_req(op_read, 14'h03ff, 1);
    arr.mem[14'h0400] = 8'h3c;
    dbg_req(op_read, 14'h0400, 0);
    chk(dbg_rdata, 8'h3c);
    dbg_wdata = 8'h96;
    dbg_req(op_write, 14'h0402, 0);
    chk(arr.mem[14'h0402], 8'h96);
    dbg_req(op_erase, 14'h3a00, 1);
    dbg_req(op_write, LOCK_ADDR, 1);
    dbg_req(op_read, RESV_BASE, 1);
    core_req(kind_code_read, RESV_BASE, 8'h00);
    chk({core_rvalid, core_rdata}, {1'b1, RESV_RDATA});
    exec_addr = 14'h0200;
    core_req(kind_code_read, 14'h0100, 8'h00);
    @(negedge clock);
    chk(core_rvalid, 1);
    exec_addr = 14'h1000;
    core_req(kind_code_read, 14'h03ff, 8'h00);
    chk({sys_reset_req, flash_fault_flag}, 2'b11);
    do_reset(0);
    chk(flash_fault_flag, 1);
    dbg_req(op_mass, 14'h0000, 0);
    chk(lock_setting, 8'hff);
    do_reset(1);
    chk(flash_fault_flag, 0);
  endtask
  task automatic t_lock_byte();
    dbg_req(op_erase, 14'h3a00, 0);
    pulse_ctl(2'b11);
    keys();
    core_req(kind_xmove_write, 14'h3a10, 8'h00);
    chk(sys_reset_req, 1);
    do_reset(0);
    pulse_ctl(2'b01);
    keys();
    core_req(kind_xmove_write, LOCK_ADDR, 8'hfe);
    chk(arr_cmd, cmd_prog);
    wait_idle();
    chk(lock_setting, 8'hff);
    keys();
    core_req(kind_xmove_write, LOCK_ADDR, 8'hfc);
    chk(sys_reset_req, 1);
    do_reset(0);
    chk(lock_setting, 8'hfe);
  endtask

  initial begin
    do_reset(1);
    chk({store_write_enable, store_erase_enable, key_state, lock_setting}, 12'h0ff);
    t_write();
    do_reset(0);
    t_pair();
    do_reset(0);
    t_erase();
    do_reset(0);
    t_lock();
    t_lock_byte();
    tally_and_finish();
  end
endmodule // flash_sequencer_bench

bind flash_sequencer flash_seq_assertions #(.LOCK_ADDR(LOCK_ADDR), .RESV_BASE(RESV_BASE)) u_chk (
  .clock, .srst, .pair_write_enable, .core_kind, .core_addr, .dbg_valid, .dbg_addr, .core_stall,
  .core_rvalid, .ext_ram_rd, .ext_ram_wr, .irq_hold, .dbg_denied, .arr_cmd, .arr_pair, .arr_busy,
  .store_write_enable, .store_erase_enable, .key_state, .lock_setting, .flash_fault_flag,
  .sys_reset_req);
